/* File: hdl/psh_handover.sv */
`timescale 1ns/1ps
module psh_handover
  import psh_pkg::*;
(
  input wire logic clk_sys_i, // system clock
  input wire logic resetn_i, // async active-low reset
  input wire logic clk_link_i, // contactless link clock
  input wire logic passthrough_enable_i, // pass-through mode on
  input wire logic [1:0] event_pin_release_select_i, // config bits 5:4
  input wire logic [1:0] event_pin_assert_select_i, // config bits 3:2
  input wire logic host_addressed_i, // host address match pulse
  input wire psh_access_s host_acc_i, // host buffer access end
  input wire psh_access_s rf_acc_i, // reader access end, link domain
  output logic host_granted_o, // host access accepted
  output logic host_refused_o, // host access refused
  output logic rf_granted_o, // reader access accepted, link domain
  output psh_status_s session_status_register_o, // status flags
  output logic field_detect_pin_o // event pin, active high
);
  // status flags, system domain
  // only the owner may touch the buffer; idle is neither set
  logic rf_own; // reader holds the buffer
  logic host_own; // host holds the buffer
  logic full_host; // buffer waits for the host
  logic full_rf; // buffer waits for the reader
  logic ev_pin; // event pin level

  // link side: toggle per accepted reader access end
  // a toggle survives the crossing where a one-cycle pulse would not
  logic rf_tog; // flips once per accepted reader access
  logic rf_wr_l; // kind of the last accepted access
  logic rf_term_l; // last accepted access hit the terminator
  logic [2:0] tog_sync; // toggle synchroniser plus history bit
  logic rf_wr_s1; // access kind, first stage
  logic rf_wr_s2; // access kind, second stage
  logic rf_term_s1; // terminator hit, first stage
  logic rf_term_s2; // terminator hit, second stage
  logic own_s1; // reader ownership, first link stage
  logic own_s2; // reader ownership, second link stage

  // reader access in buffer window, before ownership check
  wire rf_in_buf = rf_acc_i.valid && passthrough_enable_i && rf_acc_i.page >= PSH_PAGE_FIRST;
  // reader may only touch buffer while it owns it
  wire rf_ok = rf_in_buf && own_s2;
  assign rf_granted_o = rf_ok;

  // link-domain capture of the accepted access
  always_ff @(posedge clk_link_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      rf_tog <= 1'b0;
      rf_wr_l <= 1'b0;
      rf_term_l <= 1'b0;
    end
    else if (rf_ok)
    begin
      rf_tog <= ~rf_tog;
      rf_wr_l <= rf_acc_i.write;
      rf_term_l <= rf_acc_i.page == PSH_PAGE_TERM;
    end
  end

  // ownership level into link domain
  always_ff @(posedge clk_link_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      own_s1 <= 1'b0;
      own_s2 <= 1'b0;
    end
    else
    begin
      own_s1 <= rf_own;
      own_s2 <= own_s1;
    end
  end

  // toggle and held data into system domain
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      tog_sync <= 3'h0;
      rf_wr_s1 <= 1'b0;
      rf_wr_s2 <= 1'b0;
      rf_term_s1 <= 1'b0;
      rf_term_s2 <= 1'b0;
    end
    else
    begin
      tog_sync <= {tog_sync[1:0], rf_tog};
      rf_wr_s1 <= rf_wr_l;
      rf_wr_s2 <= rf_wr_s1;
      rf_term_s1 <= rf_term_l;
      rf_term_s2 <= rf_term_s1;
    end
  end

  // event pulse once toggle settled; data stable by then
  // the held kind and page bits change only with the toggle, so they
  // have settled through their own two stages when the edge is seen
  wire rf_evt = tog_sync[2] ^ tog_sync[1];
  wire rf_wr_term = rf_evt && rf_wr_s2 && rf_term_s2;
  wire rf_rd_term = rf_evt && !rf_wr_s2 && rf_term_s2;

  // host refused unless it owns buffer and reader does not
  // a refused access leaves every flag as it was
  wire host_ok = host_acc_i.valid && !rf_own && host_own;
  assign host_granted_o = host_ok;
  assign host_refused_o = host_acc_i.valid && !host_ok;
  wire host_wr_term = host_ok && host_acc_i.write && host_acc_i.page == PSH_HOST_TERM;
  wire host_rd_term = host_ok && !host_acc_i.write && host_acc_i.page == PSH_PAGE_TERM;

  // arbitration: idle means nobody owns
  // a full buffer for the reader keeps the host out until it is read
  wire idle = !rf_own && !host_own;
  wire host_take = host_addressed_i && idle && !full_rf;
  wire rf_take = idle && full_rf;

  // next flag values
  wire next_rf_own = rf_take ? 1'b1 : (rf_wr_term || rf_rd_term) ? 1'b0 : rf_own;
  wire next_host_own = host_take ? 1'b1 : (host_wr_term || host_rd_term) ? 1'b0 : host_own;
  wire next_full_host = (rf_wr_term && rf_own) ? 1'b1 : host_rd_term ? 1'b0 : full_host;
  wire next_full_rf = host_wr_term ? 1'b1 : (rf_rd_term && rf_own) ? 1'b0 : full_rf;

  // event pin: select codes pick which handover drives it
  // set wins over release should both fall in one cycle
  wire ev_set = (event_pin_assert_select_i == PSH_EV_DATA_READY && rf_wr_term && rf_own)
    || (event_pin_assert_select_i == PSH_EV_READER_DONE && rf_rd_term && rf_own);
  wire ev_clr = (event_pin_release_select_i == PSH_EV_DATA_READY && host_rd_term)
    || (event_pin_release_select_i == PSH_EV_READER_DONE && host_wr_term);
  wire next_ev = ev_set ? 1'b1 : ev_clr ? 1'b0 : ev_pin;

  // flag registers
  // every flag clears on reset so the buffer starts in arbitration idle
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      rf_own <= PSH_FLAG_RESET;
      host_own <= PSH_FLAG_RESET;
      full_host <= PSH_FLAG_RESET;
      full_rf <= PSH_FLAG_RESET;
      ev_pin <= PSH_FLAG_RESET;
    end
    else
    begin
      rf_own <= next_rf_own;
      host_own <= next_host_own;
      full_host <= next_full_host;
      full_rf <= next_full_rf;
      ev_pin <= next_ev;
    end
  end

  // status visible to polling parties
  assign session_status_register_o = '{rf_own, host_own, full_host, full_rf};
  assign field_detect_pin_o = ev_pin;

  a_rf_handover: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (rf_wr_term && rf_own && !host_rd_term) |=> full_host && !rf_own)
    else $error("reader terminator write did not hand over");
  a_host_take: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    host_take |=> host_own)
    else $error("host ownership not taken");
  a_host_release: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    host_rd_term |=> !full_host && !host_own)
    else $error("host read of terminator did not release");
  // host handover: buffer released and marked full, then reader takes it
  sequence s_host_released;
    full_rf && !host_own;
  endsequence

  sequence s_reader_takes;
    rf_own;
  endsequence

  a_host_handover: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    host_wr_term |=> s_host_released ##1 s_reader_takes)
    else $error("host terminator write did not hand over");
  a_rf_take: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (idle && full_rf) |=> rf_own)
    else $error("reader ownership not taken");
  a_rf_release: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (rf_rd_term && rf_own && !host_wr_term) |=> !full_rf && !rf_own)
    else $error("reader read of terminator did not release");
  a_event_ready: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (event_pin_assert_select_i == PSH_EV_DATA_READY && rf_wr_term && rf_own) |=> field_detect_pin_o)
    else $error("event pin missed data ready");
  a_event_done: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (event_pin_assert_select_i == PSH_EV_READER_DONE && rf_rd_term && rf_own) |=> field_detect_pin_o)
    else $error("event pin missed reader done");
  a_mutual_owner: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    !(rf_own && host_own) && !(host_granted_o && rf_own))
    else $error("both sides own the buffer");
  // a refused host access must not move host ownership
  a_refuse_quiet: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (host_refused_o && !host_take) |=> $stable(host_own))
    else $error("refused host access changed ownership");
  // data-ready release select drops the pin after the host read the terminator
  a_pin_release: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (event_pin_release_select_i == PSH_EV_DATA_READY && host_rd_term && !ev_set) |=> !field_detect_pin_o)
    else $error("event pin not released");
  a_buffer_map: assert property (@(posedge clk_link_i) disable iff (!resetn_i)
    rf_granted_o |-> rf_acc_i.page >= PSH_PAGE_FIRST && passthrough_enable_i)
    else $error("reader granted outside buffer window");
endmodule

/* File: hdl/psh_pkg.sv */
// Functional notes
// - reader write of page FFh hands buffer to host
// - event pin signals host data ready, if selected
// - host addressed sets host ownership under arbitration
// - host read of terminator clears flags, goes idle
// - host write of block FBh sets reader-ready, idle
// - then contactless ownership set under arbitration
// - reader read of terminator clears reader flags
// - event pin signals reader finished reading, if selected
// - buffer maps to reader pages F0h to FFh
package psh_pkg;
  localparam logic [7:0] PSH_PAGE_FIRST = 8'hF0; // first buffer page, reader side
  localparam logic [7:0] PSH_PAGE_TERM = 8'hFF; // reader terminator page
  localparam logic [7:0] PSH_HOST_TERM = 8'hFB; // host terminator block
  // event pin select codes (two 2-bit fields)
  localparam logic [1:0] PSH_EV_DATA_READY = 2'h3; // host data ready
  localparam logic [1:0] PSH_EV_READER_DONE = 2'h2; // reader finished reading
  localparam logic PSH_FLAG_RESET = 1'b0; // all flags clear after reset

  // one access request from either side
  typedef struct packed
  {
    logic valid; // one-cycle access strobe
    logic write; // 1 write, 0 read
    logic [7:0] page; // page or block address
  } psh_access_s;

  // status flags seen by both parties
  typedef struct packed
  {
    logic contactless_owns_buffer;
    logic host_owns_buffer;
    logic buffer_full_for_host;
    logic buffer_full_for_reader;
  } psh_status_s;
endpackage

/* File: test/psh_handover_test.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin mismatches++; $display("[ERR] %0t mismatch", $time); end end
module psh_handover_test
  import psh_pkg::*;
;
  logic clk_sys_i = 1'b0;
  logic clk_link_i = 1'b0;
  logic resetn_i = 1'b0;
  logic pass_en = 1'b1; // buffer window on
  logic [1:0] rel_sel = 2'h0;
  logic [1:0] ast_sel = 2'h0;
  logic host_addr = 1'b0;
  psh_access_s host_acc = '0;
  logic tgl = 1'b0; // reader request toggle
  logic rw = 1'b0;
  logic [7:0] rp = 8'h00;
  psh_access_s rf_acc;
  logic h_gnt, h_ref, pin;
  logic rf_gnt; // reader grant, link domain
  int rf_grants = 0; // reader accesses accepted
  always @(posedge clk_link_i) if (rf_gnt) rf_grants++;
  psh_status_s st;
  int mismatches = 0;
  int n_tests = 0;
  always #50 clk_sys_i = ~clk_sys_i;
  always #7.5 clk_link_i = ~clk_link_i;
  psh_handover dut_u (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .clk_link_i(clk_link_i),
    .passthrough_enable_i(pass_en), .event_pin_release_select_i(rel_sel), .event_pin_assert_select_i(ast_sel),
    .host_addressed_i(host_addr), .host_acc_i(host_acc), .rf_acc_i(rf_acc), .host_granted_o(h_gnt),
    .host_refused_o(h_ref), .rf_granted_o(rf_gnt), .session_status_register_o(st), .field_detect_pin_o(pin));
  psh_reader_model rd_u (.clk_link_i(clk_link_i), .resetn_i(resetn_i), .req_toggle_i(tgl),
    .req_write_i(rw), .req_page_i(rp), .rf_acc_o(rf_acc));
  // expected flag set
  function automatic psh_status_s exp_st(input logic c, h, fh, fr);
    exp_st = psh_status_s'{c, h, fh, fr};
  endfunction
  task end_sim;
    $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // let flags settle, then compare
  task automatic chk_st(input logic c, h, fh, fr);
    repeat (2) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    `CHK(st, exp_st(c, h, fh, fr))
  endtask
  // host command end, grant or refusal seen in the same cycle
  task automatic host_op(input logic w, input logic [7:0] pg, input logic gnt);
    @(posedge clk_sys_i);
    host_acc <= psh_access_s'{1'b1, w, pg};
    @(negedge clk_sys_i);
    `CHK({h_gnt, h_ref}, {gnt, ~gnt})
    @(posedge clk_sys_i);
    host_acc <= psh_access_s'{1'b0, ~w, ~pg};
  endtask
  task automatic addr;
    @(posedge clk_sys_i);
    host_addr <= 1'b1;
    @(posedge clk_sys_i);
    host_addr <= 1'b0;
  endtask
  // reader command, spaced well apart for the crossing
  task automatic rf_op(input logic w, input logic [7:0] pg);
    @(posedge clk_sys_i);
    rw <= w;
    rp <= pg;
    tgl <= ~tgl;
    repeat (20) @(posedge clk_sys_i);
  endtask
  initial
  begin
    void'($urandom(41003));
    repeat (16) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    chk_st(0, 0, 0, 0);
    `CHK(pin, 1'b0)
    ast_sel <= 2'h3;
    rel_sel <= 2'h3;
    host_op(1, 8'hFB, 0);
    rf_op(0, 8'hFF);
    chk_st(0, 0, 0, 0);
    addr();
    chk_st(0, 1, 0, 0);
    host_op(1, 8'($urandom_range(0, 250)), 1);
    chk_st(0, 1, 0, 0);
    host_op(1, 8'hFB, 1);
    chk_st(1, 0, 0, 1);
    host_op(0, 8'hFF, 0);
    pass_en <= 1'b0;
    rf_op(0, 8'hFF);
    chk_st(1, 0, 0, 1);
    pass_en <= 1'b1;
    rf_op(0, 8'($urandom_range(0, 239)));
    rf_op(0, 8'($urandom_range(240, 254)));
    chk_st(1, 0, 0, 1);
    rf_op(1, 8'hFF);
    `CHK(st.buffer_full_for_host, 1'b1)
    `CHK(pin, 1'b1)
    rf_op(0, 8'hFF);
    chk_st(0, 0, 1, 0);
    addr();
    host_op(0, 8'hFF, 1);
    chk_st(0, 0, 0, 0);
    `CHK(pin, 1'b0)
    ast_sel <= 2'h2;
    rel_sel <= 2'h0;
    addr();
    host_op(1, 8'hFB, 1);
    rf_op(0, 8'hFF);
    chk_st(0, 0, 0, 0);
    `CHK(pin, 1'b1)
    `CHK(rf_grants, 4)
    end_sim();
  end
  // watchdog well beyond the expected run
  initial
  begin
    #300000;
    mismatches++;
    end_sim();
  end
endmodule

/* File: test/psh_reader_model.sv */
`timescale 1ns/1ps
// reader side: one command-end strobe per request toggle
module psh_reader_model
  import psh_pkg::*;
(
  input wire logic clk_link_i, // link clock
  input wire logic resetn_i, // async reset
  input wire logic req_toggle_i, // flips once per command
  input wire logic req_write_i, // command kind
  input wire logic [7:0] req_page_i, // command page
  output psh_access_s rf_acc_o // command end to device
);
  logic [2:0] sync; // toggle synchroniser and history
  wire fire = sync[2] ^ sync[1]; // new command seen
  // strobe for one link cycle, page scrambled when idle
  always_ff @(posedge clk_link_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      sync <= 3'h0;
      rf_acc_o <= '0;
    end
    else
    begin
      sync <= {sync[1:0], req_toggle_i};
      rf_acc_o.valid <= fire;
      rf_acc_o.write <= fire ? req_write_i : ~rf_acc_o.write;
      rf_acc_o.page <= fire ? req_page_i : ~rf_acc_o.page;
    end
  end
endmodule
